// >>> verilog/link_status_register.v
// Notes on behaviour
// - Status word read-only at 0x0008
// - Bit 0 shows duplex: MAC config if forced, else PHY duplex
// - Bit 1 high when link established
// - Link flag valid only with set-link-up
// - Link flag follows internal PHY link
// - Bits 3:2 and 5 reserved, read zero
// - Bit 4 set on XOFF with flow control
// - Bit 4 clears on timer expiry or XON
// - Bits 7:6 speed: 00/01/10 codes
// - Speed normally follows PHY speed indication
// - Forced speed shows MAC config, auto shows latched PHY speed
// - Auto speed latched once per link-up
`timescale 1ns/1ns
`include "link_status_consts.vh"

module link_status_register #(
    parameter ADDR_W = 16
) (
    input  wire              clk_sys_in,
    input  wire              rstn_in,
    input  wire [ADDR_W-1:0] addr_in,
    input  wire [31:0]       wdata_in,
    input  wire              wr_in,
    input  wire              rd_in,
    output reg  [31:0]       rdata_out,
    input  wire              phy_link_in,
    input  wire [1:0]        phy_speed_indication_in,
    input  wire              phy_duplex_in,
    input  wire              xoff_rx_in,
    input  wire              xon_rx_in,
    input  wire              pause_expired_in,
    output reg               duplex_full_flag_out,
    output reg               link_established_flag_out,
    output reg               tx_paused_flag_out,
    output reg  [1:0]        link_speed_out
);

// ------------------------------------------------------------
// Pin synchronisers (three stages, second and third agree)
// ------------------------------------------------------------
reg [2:0] link_sync;
reg [5:0] spd_sync;
reg [2:0] dup_sync;
reg       phy_link;
reg [1:0] phy_speed_indication;
reg       phy_duplex;

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        link_sync <= 3'h0;
    end else begin
        link_sync <= {link_sync[1:0], phy_link_in};
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        spd_sync <= 6'h00;
    end else begin
        spd_sync <= {spd_sync[3:0], phy_speed_indication_in};
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        dup_sync <= 3'h0;
    end else begin
        dup_sync <= {dup_sync[1:0], phy_duplex_in};
    end
end

// ------------------------------------------------------------
// Agree stage, stages two and three must match
// ------------------------------------------------------------

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        phy_link <= 1'b0;
    end else if (link_sync[2] == link_sync[1]) begin
        phy_link <= link_sync[2];
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        phy_speed_indication <= 2'h0;
    end else if (spd_sync[5:4] == spd_sync[3:2]) begin
        phy_speed_indication <= spd_sync[5:4];
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        phy_duplex <= 1'b0;
    end else if (dup_sync[2] == dup_sync[1]) begin
        phy_duplex <= dup_sync[2];
    end
end

// ------------------------------------------------------------
// Control register
// ------------------------------------------------------------
reg  [31:0] link_control;

// ------------------------------------------------------------
// Control fields
// ------------------------------------------------------------
wire        set_link_up_ctl = link_control[`CTL_SET_LINK_UP];
wire        force_speed     = link_control[`CTL_FORCE_SPEED];
wire        force_duplex    = link_control[`CTL_FORCE_DUPLEX];
wire        auto_speed      = link_control[`CTL_AUTO_SPEED];
wire        flow_en         = link_control[`CTL_FLOW_EN];
wire [1:0]  ctl_speed       = link_control[`CTL_SPEED_MSB:`CTL_SPEED_LSB];

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        link_control <= `CTL_RESET;
    end else if (wr_in && is_control_addr(addr_in)) begin
        link_control <= wdata_in & `CTL_WRITE_MASK;
    end
end

// ------------------------------------------------------------
// Address decode
// ------------------------------------------------------------

function is_control_addr;
    input [ADDR_W-1:0] addr;
    begin
        is_control_addr = (addr == `ADDR_LINK_CONTROL);
    end
endfunction

function is_status_addr;
    input [ADDR_W-1:0] addr;
    begin
        is_status_addr = (addr == `ADDR_DEVICE_LINK_STATUS);
    end
endfunction

// ------------------------------------------------------------
// Field selection
// ------------------------------------------------------------

function [1:0] legal_speed;
    input [1:0] code;
    begin
        if (code == 2'h3) begin
            legal_speed = `SPEED_1000;
        end else begin
            legal_speed = code;
        end
    end
endfunction

function [1:0] pick_speed;
    input       forced;
    input       auto;
    input [1:0] forced_code;
    input [1:0] auto_code;
    input [1:0] phy_code;
    begin
        if (forced) begin
            pick_speed = forced_code;
        end else if (auto) begin
            pick_speed = auto_code;
        end else begin
            pick_speed = phy_code;
        end
        pick_speed = legal_speed(pick_speed);
    end
endfunction

function pick_duplex;
    input forced;
    input forced_val;
    input phy_val;
    begin
        if (forced) begin
            pick_duplex = forced_val;
        end else begin
            pick_duplex = phy_val;
        end
    end
endfunction

function link_flag;
    input ctl_up;
    input phy_up;
    begin
        link_flag = ctl_up & phy_up;
    end
endfunction

function pause_next;
    input current;
    input enabled;
    input xoff;
    input xon;
    input expired;
    begin
        pause_next = current;
        if (xon || expired || !enabled) begin
            pause_next = 1'b0;
        end else if (xoff) begin
            pause_next = 1'b1;
        end
    end
endfunction

// ------------------------------------------------------------
// Status packing
// ------------------------------------------------------------

function [31:0] pack_status;
    input       duplex;
    input       link;
    input       paused;
    input [1:0] speed;
    begin
        pack_status = 32'h00000000;
        pack_status[`BIT_DUPLEX_FULL] = duplex;
        pack_status[`BIT_LINK_EST] = link;
        pack_status[`BIT_TX_PAUSED] = paused;
        pack_status[`SPEED_MSB:`SPEED_LSB] = speed;
    end
endfunction

// ------------------------------------------------------------
// Auto speed capture, once per link-up
// ------------------------------------------------------------
reg       auto_done;
reg [1:0] auto_speed_val;

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        auto_done <= 1'b0;
    end else if (!phy_link) begin
        auto_done <= 1'b0;
    end else if (auto_speed) begin
        auto_done <= 1'b1;
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        auto_speed_val <= `SPEED_10;
    end else if (phy_link && auto_speed && !auto_done) begin
        auto_speed_val <= legal_speed(phy_speed_indication);
    end
end

// ------------------------------------------------------------
// Status fields
// ------------------------------------------------------------
reg [1:0] next_speed;
reg       next_duplex;
reg       next_link;
reg       next_paused;

// ------------------------------------------------------------
// Speed, duplex and link select
// ------------------------------------------------------------

always @* begin
    next_speed = pick_speed(force_speed, auto_speed, ctl_speed, auto_speed_val,
                            phy_speed_indication);
end

always @* begin
    next_duplex = pick_duplex(force_duplex, link_control[`CTL_FULL_DUPLEX], phy_duplex);
    next_link   = link_flag(set_link_up_ctl, phy_link);
end

// ------------------------------------------------------------
// Pause flag, a clear beats a set in one cycle
// ------------------------------------------------------------

always @* begin
    next_paused = pause_next(tx_paused_flag_out, flow_en, xoff_rx_in, xon_rx_in,
                             pause_expired_in);
end

// ------------------------------------------------------------
// Status registers
// ------------------------------------------------------------

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        duplex_full_flag_out <= 1'b0;
    end else begin
        duplex_full_flag_out <= next_duplex;
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        link_established_flag_out <= 1'b0;
    end else begin
        link_established_flag_out <= next_link;
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        tx_paused_flag_out <= 1'b0;
    end else begin
        tx_paused_flag_out <= next_paused;
    end
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        link_speed_out <= `SPEED_10;
    end else begin
        link_speed_out <= next_speed;
    end
end

// ------------------------------------------------------------
// Read port
// ------------------------------------------------------------
reg [31:0] status_word;

always @* begin
    status_word = pack_status(duplex_full_flag_out, link_established_flag_out,
                              tx_paused_flag_out, link_speed_out);
end

always @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
        rdata_out <= 32'h00000000;
    end else if (rd_in && is_status_addr(addr_in)) begin
        rdata_out <= status_word;
    end else if (rd_in && is_control_addr(addr_in)) begin
        rdata_out <= link_control;
    end else begin
        rdata_out <= 32'h00000000;
    end
end

endmodule // link_status_register

// >>> verilog/link_status_consts.vh
`ifndef LINK_STATUS_CONSTS_VH
`define LINK_STATUS_CONSTS_VH

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define ADDR_DEVICE_LINK_STATUS 16'h0008
`define ADDR_LINK_CONTROL       16'h0000

// ------------------------------------------------------------
// Status word fields
// ------------------------------------------------------------
`define BIT_DUPLEX_FULL   0
`define BIT_LINK_EST      1
`define BIT_TX_PAUSED     4
`define SPEED_LSB         6
`define SPEED_MSB         7

// ------------------------------------------------------------
// Control word fields
// ------------------------------------------------------------
`define CTL_SET_LINK_UP   0
`define CTL_FORCE_SPEED   1
`define CTL_FORCE_DUPLEX  2
`define CTL_AUTO_SPEED    3
`define CTL_FULL_DUPLEX   4
`define CTL_FLOW_EN       5
`define CTL_SPEED_LSB     8
`define CTL_SPEED_MSB     9
`define CTL_WRITE_MASK    32'h0000033F
`define CTL_RESET         32'h00000000

// ------------------------------------------------------------
// Speed codes
// ------------------------------------------------------------
`define SPEED_10          2'h0
`define SPEED_100         2'h1
`define SPEED_1000        2'h2

`endif

// >>> tb/link_status_props.sv
`timescale 1ns/1ns
module link_status_props (
    input wire        clk_sys_in,
    input wire        rstn_in,
    input wire [15:0] addr_in,
    input wire        rd_in,
    input wire [31:0] rdata_out,
    input wire        phy_link_in,
    input wire        xon_rx_in,
    input wire        xoff_rx_in,
    input wire        pause_expired_in,
    input wire        duplex_full_flag_out,
    input wire        link_established_flag_out,
    input wire        tx_paused_flag_out,
    input wire [1:0]  link_speed_out
);
    // --------------
    // Properties
    // --------------
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data not idle");
    a_status_map: assert property (rd_in && addr_in == 16'h0008 |=>
        rdata_out == {24'h0, $past(link_speed_out), 1'b0, $past(tx_paused_flag_out), 2'h0,
        $past(link_established_flag_out), $past(duplex_full_flag_out)})
        else $error("status word mismatch");
    a_unmapped_rd: assert property (rd_in && addr_in != 16'h0008 && addr_in != 16'h0000
        |=> rdata_out == 32'h0) else $error("unmapped read not zero");
    a_pause_set: assert property ($rose(tx_paused_flag_out) |-> $past(xoff_rx_in))
        else $error("pause without xoff");
    a_pause_clear: assert property (xon_rx_in || pause_expired_in |=> !tx_paused_flag_out)
        else $error("pause not cleared");
    a_speed_code: assert property (link_speed_out != 2'h3)
        else $error("bad speed code");
    a_link_drop: assert property ($fell(phy_link_in) |-> ##[1:6] !link_established_flag_out)
        else $error("link flag stuck");
endmodule // link_status_props

bind link_status_register link_status_props u_props (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .phy_link_in(phy_link_in), .xon_rx_in(xon_rx_in),
    .xoff_rx_in(xoff_rx_in), .pause_expired_in(pause_expired_in),
    .duplex_full_flag_out(duplex_full_flag_out),
    .link_established_flag_out(link_established_flag_out),
    .tx_paused_flag_out(tx_paused_flag_out), .link_speed_out(link_speed_out));

// >>> tb/link_status_register_tb.sv
`timescale 1ns/1ns
module link_status_register_tb;
    reg         clk_sys_in = 0, rstn_in = 0, wr = 0, rd = 0, link = 0, dup = 0;
    reg  [15:0] addr = 16'h0;
    reg  [31:0] wdata = 32'h0;
    reg  [1:0]  spd = 2'h0;
    reg  [2:0]  ev = 3'h0;
    wire [31:0] rdata;
    wire        dup_o, lnk_o, pau_o;
    wire [1:0]  spd_o;
    integer     num_errors = 0, total_checks = 0, i;
    link_status_register dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .phy_link_in(link),
        .phy_speed_indication_in(spd), .phy_duplex_in(dup), .xoff_rx_in(ev[2]),
        .xon_rx_in(ev[1]), .pause_expired_in(ev[0]), .duplex_full_flag_out(dup_o),
        .link_established_flag_out(lnk_o), .tx_paused_flag_out(pau_o),
        .link_speed_out(spd_o));
    // --------------
    // Tasks
    // --------------
    initial forever #10 clk_sys_in = ~clk_sys_in;
    task chk(input [31:0] s, input [31:0] e); begin
        total_checks++;
        if (s !== e) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
        end
    end endtask
    task wr_reg(input [15:0] a, input [31:0] d); begin
        @(posedge clk_sys_in); addr <= a; wdata <= d; wr <= 1;
        @(posedge clk_sys_in); wr <= 0;
        repeat (2) @(posedge clk_sys_in);
    end endtask
    task rd_chk(input [15:0] a, input [31:0] e); begin
        @(posedge clk_sys_in); addr <= a; rd <= 1;
        @(posedge clk_sys_in); rd <= 0;
        #1 chk(rdata, e);
        if (a == 16'h0008) chk({24'h0, spd_o, 1'b0, pau_o, 2'h0, lnk_o, dup_o}, e);
    end endtask
    task pulse(input [2:0] v); begin
        @(posedge clk_sys_in); ev <= v;
        @(posedge clk_sys_in); ev <= 3'h0;
    end endtask
    task wrap_up; begin
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    end endtask
    initial begin #100000; num_errors++; wrap_up; end
    initial begin
        repeat (10) @(posedge clk_sys_in); rstn_in <= 1;
        rd_chk(16'h0008, 32'h0);
        rd_chk(16'h0004, 32'h0);
        wr_reg(16'h0000, 32'h21); link <= 1; dup <= 1;
        for (i = 0; i < 3; i++) begin
            spd <= i[1:0]; repeat (8) @(posedge clk_sys_in);
            rd_chk(16'h0008, {24'h0, i[1:0], 6'h03});
        end
        wr_reg(16'h0008, 32'hFF); rd_chk(16'h0008, 32'h83);
        pulse(3'h4); rd_chk(16'h0008, 32'h93);
        pulse(3'h2); rd_chk(16'h0008, 32'h83);
        pulse(3'h4); pulse(3'h1); rd_chk(16'h0008, 32'h83);
        wr_reg(16'h0000, 32'h20); rd_chk(16'h0008, 32'h81);
        wr_reg(16'h0000, 32'h127); rd_chk(16'h0008, 32'h42);
        wr_reg(16'h0000, 32'h29); spd <= 2'h1; repeat (8) @(posedge clk_sys_in);
        rd_chk(16'h0008, 32'h83);
        link <= 0; repeat (8) @(posedge clk_sys_in);
        rd_chk(16'h0008, 32'h81);
        link <= 1; repeat (8) @(posedge clk_sys_in);
        rd_chk(16'h0008, 32'h43);
        wrap_up;
    end
endmodule // link_status_register_tb
